// file: logic/pic_defs.vh
// Constants for the priority interrupt controller
`ifndef PIC_DEFS_VH
`define PIC_DEFS_VH

// ------------------------------------------------------------
// Register indices (byte address is four times the index)
// ------------------------------------------------------------
`define PIC_IDX_PRIO_A     16'hfff0
`define PIC_IDX_PRIO_B     16'hfff1
`define PIC_IDX_PRIO_C     16'hfff2
`define PIC_IDX_PRIO_D     16'hfff3
`define PIC_IDX_XFER_EN    16'hfff4
`define PIC_IDX_EV_STAT    16'hfff8
`define PIC_IDX_EV_EN      16'hfff9
`define PIC_IDX_EV_CLR     16'hfffa
`define PIC_IDX_STATE      16'hfffb

// ------------------------------------------------------------
// Priority register layout
// ------------------------------------------------------------
`define PIC_PRIO_WMASK     8'h77
`define PIC_PRIO_RST       8'h00
`define PIC_FLD_HI_LSB     4
`define PIC_FLD_LO_LSB     0

// ------------------------------------------------------------
// Sources
// ------------------------------------------------------------
`define PIC_NUM_SRC        21
`define PIC_SRC_RST        21'h000000
`define PIC_XFER_CAPABLE   21'h1cdddf
`define PIC_SERIAL_MASK    21'h0e0000
`define PIC_NMI_LEVEL      3'h7
`define PIC_NMI_VEC        8'h16

// ------------------------------------------------------------
// Context save and prefetch state counts
// ------------------------------------------------------------
`define PIC_SAVE_MIN_ONCHIP  8'h10
`define PIC_SAVE_MAX_ONCHIP  8'h15
`define PIC_SAVE_MIN_EXT     8'h1c
`define PIC_SAVE_MIN_PERWAIT 8'h06
`define PIC_SAVE_MAX_EXT     8'h29
`define PIC_SAVE_MAX_PERWAIT 8'h0a

// ------------------------------------------------------------
// Event bits in status, enable and clear registers
// ------------------------------------------------------------
`define PIC_EV_W           4
`define PIC_EV_CPU         0
`define PIC_EV_XFER        1
`define PIC_EV_BYPASS      2
`define PIC_EV_DONE        3

`endif

// file: logic/pic_ctrl.v
// Priority interrupt controller with APB register access
// Behaviour
// - Each maskable source has a 3-bit level, 7 highest, 0 lowest.
// - Four priority registers hold two fields, bits 6..4 and 2..0.
// - Bits 7 and 3 of priority registers ignore writes, read zero.
// - Reset clears priority registers to zero, masking all but non-maskable.
// - Highest-level pending request is chosen; lower ones stay pending.
// - Accept only when level strictly exceeds CPU mask, else keep pending.
// - Equal levels resolved by fixed ranking, loser stays pending.
// - Resolution takes two clocks, so priority writes act late.
// - Address error, trace and non-maskable bypass level arbitration and mask.
// - Transfer-enable bit set on a transfer-capable source starts transfer controller, else CPU exception.
// - Transfer start clears request, except serial port requests.
// - CPU service waits for instruction end, then saves context.
// - Service clears trace bit, loads mask with level; non-maskable loads 7.
// - Vector fetch one word minimum mode, two words maximum mode.
// - Requests during a transfer wait for its end plus one instruction.
// - Save takes 16/21 states on-chip, 28+6m/41+10m external.
// - Ranking: external zero, one, timers, byte timer, serial, converter.
// - Each source has its own vector entry.
`include "pic_defs.vh"

module pic_ctrl #(
    parameter [7:0] ADDR_ERR_VEC = 8'h08,
    parameter [7:0] TRACE_VEC    = 8'h0c
) (
    input  wire        ref_clk,
    input  wire        rst_b,
    input  wire [17:0] paddr,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire [20:0] src_req,
    output reg  [20:0] src_clr,
    input  wire        nmi_req,
    input  wire        addr_err_req,
    input  wire        trace_req,
    input  wire [2:0]  cpu_mask_level,
    input  wire        max_mode,
    input  wire        ext_stack,
    input  wire [3:0]  wait_states,
    input  wire        instr_done,
    input  wire        xfer_busy,
    output wire        svc_valid,
    output reg         svc_to_xfer,
    output reg  [2:0]  svc_level,
    output reg  [8:0]  svc_vec_addr,
    input  wire        svc_ack,
    output wire        ctx_save,
    output wire        save_code_page,
    output wire [1:0]  vec_words,
    output reg         trace_clr,
    output reg         mask_load,
    output reg  [2:0]  new_mask,
    output reg         exc_done,
    output wire        irq
);

    // ------------------------------------------------------------
    // States
    // ------------------------------------------------------------
    localparam [1:0] ST_IDLE  = 2'h0;
    localparam [1:0] ST_OFFER = 2'h1;
    localparam [1:0] ST_WAIT  = 2'h2;
    localparam [1:0] ST_SAVE  = 2'h3;

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    // Field of the packed priority word that serves source i
    function [2:0] src_level;
        input [4:0]  i;
        input [31:0] p;
        reg   [7:0]  r;
        reg          hi;
        begin
            r  = 8'h00;
            hi = 1'b1;
            case (i)
                5'd0:                       begin r = p[7:0];   hi = 1'b1; end
                5'd1:                       begin r = p[7:0];   hi = 1'b0; end
                5'd2, 5'd3, 5'd4, 5'd5:     begin r = p[15:8];  hi = 1'b1; end
                5'd6, 5'd7, 5'd8, 5'd9:     begin r = p[15:8];  hi = 1'b0; end
                5'd10, 5'd11, 5'd12, 5'd13: begin r = p[23:16]; hi = 1'b1; end
                5'd14, 5'd15, 5'd16:        begin r = p[23:16]; hi = 1'b0; end
                5'd17, 5'd18, 5'd19:        begin r = p[31:24]; hi = 1'b1; end
                default:                    begin r = p[31:24]; hi = 1'b0; end
            endcase
            src_level = hi ? r[`PIC_FLD_HI_LSB+2:`PIC_FLD_HI_LSB]
                           : r[`PIC_FLD_LO_LSB+2:`PIC_FLD_LO_LSB];
        end
    endfunction

    // Minimum-mode vector address; maximum mode doubles it
    function [7:0] src_vec;
        input [4:0] i;
        begin
            if (i < 5'd2)
                src_vec = 8'h40 + {2'h0, i, 1'b0};
            else if (i < 5'd17)
                src_vec = 8'h44 + {2'h0, i, 1'b0};
            else if (i < 5'd20)
                src_vec = 8'h46 + {2'h0, i, 1'b0};
            else
                src_vec = 8'h48 + {2'h0, i, 1'b0};
        end
    endfunction

    function [8:0] vec_addr;
        input [7:0] v;
        input       mx;
        begin
            vec_addr = mx ? {v, 1'b0} : {1'b0, v};
        end
    endfunction

    function [7:0] save_states;
        input       mx;
        input       ext;
        input [3:0] m;
        begin
            if (!ext)
                save_states = mx ? `PIC_SAVE_MAX_ONCHIP : `PIC_SAVE_MIN_ONCHIP;
            else if (mx)
                save_states = `PIC_SAVE_MAX_EXT + {4'h0, m} * `PIC_SAVE_MAX_PERWAIT;
            else
                save_states = `PIC_SAVE_MIN_EXT + {4'h0, m} * `PIC_SAVE_MIN_PERWAIT;
        end
    endfunction

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    reg  [7:0]  prio_q [0:3];
    reg  [20:0] xfer_en_q;
    reg  [3:0]  ev_stat_q;
    reg  [3:0]  ev_en_q;
    reg  [1:0]  state_q;
    reg         cand_valid_q;
    reg  [4:0]  cand_idx_q;
    reg  [2:0]  cand_lvl_q;
    reg         nmi_pend_q;
    reg         aerr_pend_q;
    reg         trace_pend_q;
    reg         hold_q;
    reg  [4:0]  svc_idx_q;
    reg         mode_q;
    reg  [7:0]  cnt_q;
    reg         best_valid;
    reg  [4:0]  best_idx;
    reg  [2:0]  best_lvl;
    reg  [2:0]  lvl_i;
    reg  [31:0] rd_val;
    reg         rd_hit;
    integer     i;
    integer     j;

    wire [15:0] idx      = paddr[17:2];
    wire        setup    = psel & ~penable;
    wire        access   = psel & penable;
    wire        wr       = access & pwrite;
    wire [31:0] prio_all = {prio_q[3], prio_q[2], prio_q[1], prio_q[0]};
    wire        is_prio  = (idx[15:2] == `PIC_IDX_PRIO_A >> 2);
    wire        mapped   = is_prio | (idx == `PIC_IDX_XFER_EN) | (idx == `PIC_IDX_EV_STAT)
                         | (idx == `PIC_IDX_EV_EN) | (idx == `PIC_IDX_EV_CLR) | (idx == `PIC_IDX_STATE);
    wire        any_bypass = nmi_pend_q | aerr_pend_q | trace_pend_q;
    wire        can_take = (state_q == ST_IDLE) & ~hold_q & ~xfer_busy;
    // Candidate must still be raised, since it was sampled a clock ago
    wire        mask_ok  = cand_valid_q & src_req[cand_idx_q] & (cand_lvl_q > cpu_mask_level);
    wire        take_byp = can_take & any_bypass;
    wire        take_src = can_take & ~any_bypass & mask_ok;
    wire [20:0] xfer_ok  = xfer_en_q & `PIC_XFER_CAPABLE;
    wire        to_xfer  = xfer_ok[cand_idx_q];
    wire        save_end = (state_q == ST_SAVE) & (cnt_q == 8'h00);
    wire [3:0]  ev_set;

    assign ev_set[`PIC_EV_CPU]    = take_src & ~to_xfer;
    assign ev_set[`PIC_EV_XFER]   = take_src & to_xfer;
    assign ev_set[`PIC_EV_BYPASS] = take_byp;
    assign ev_set[`PIC_EV_DONE]   = save_end;

    assign pready         = access;
    assign pslverr        = access & (~mapped | (pwrite & ((idx == `PIC_IDX_EV_STAT) | (idx == `PIC_IDX_STATE))));
    assign svc_valid      = (state_q == ST_OFFER);
    assign ctx_save       = (state_q == ST_SAVE);
    assign save_code_page = ctx_save & mode_q;
    assign vec_words      = mode_q ? 2'h2 : 2'h1;
    assign irq            = |(ev_stat_q & ev_en_q);

    // ------------------------------------------------------------
    // Arbitration, first stage
    // ------------------------------------------------------------
    always @* begin
        best_valid = 1'b0;
        best_idx   = 5'h00;
        best_lvl   = 3'h0;
        lvl_i      = 3'h0;
        for (i = 0; i < `PIC_NUM_SRC; i = i + 1) begin
            lvl_i = src_level(i[4:0], prio_all);
            // Strict compare keeps the lower index on ties
            if (src_req[i] && (!best_valid || lvl_i > best_lvl)) begin
                best_valid = 1'b1;
                best_idx   = i[4:0];
                best_lvl   = lvl_i;
            end
        end
    end

    // ------------------------------------------------------------
    // Register read mux
    // ------------------------------------------------------------
    always @* begin
        rd_val = 32'h00000000;
        rd_hit = 1'b1;
        if (is_prio)
            rd_val = {24'h000000, prio_q[idx[1:0]] & `PIC_PRIO_WMASK};
        else if (idx == `PIC_IDX_XFER_EN)
            rd_val = {11'h000, xfer_en_q};
        else if (idx == `PIC_IDX_EV_STAT)
            rd_val = {28'h0000000, ev_stat_q};
        else if (idx == `PIC_IDX_EV_EN)
            rd_val = {28'h0000000, ev_en_q};
        else if (idx == `PIC_IDX_STATE)
            rd_val = {16'h0000, svc_idx_q, svc_level, hold_q, any_bypass, 4'h0, state_q};
        else
            rd_hit = 1'b0;
    end

    // ------------------------------------------------------------
    // APB slave and software registers
    // ------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (!rst_b) begin
            for (j = 0; j < 4; j = j + 1)
                prio_q[j] <= `PIC_PRIO_RST;
            xfer_en_q <= `PIC_SRC_RST;
            ev_en_q   <= 4'h0;
            ev_stat_q <= 4'h0;
            prdata    <= 32'h00000000;
        end else begin
            // Read data captured in setup so the access phase has no wait
            if (setup && !pwrite)
                prdata <= rd_hit ? rd_val : 32'h00000000;
            if (wr && is_prio)
                prio_q[idx[1:0]] <= pwdata[7:0] & `PIC_PRIO_WMASK;
            if (wr && idx == `PIC_IDX_XFER_EN)
                xfer_en_q <= pwdata[20:0];
            if (wr && idx == `PIC_IDX_EV_EN)
                ev_en_q <= pwdata[3:0];
            // New events win over a clear in the same clock
            if (wr && idx == `PIC_IDX_EV_CLR)
                ev_stat_q <= (ev_stat_q & ~pwdata[3:0]) | ev_set;
            else
                ev_stat_q <= ev_stat_q | ev_set;
        end
    end

    // ------------------------------------------------------------
    // Arbitration pipeline, pending bypass requests, hold-off
    // ------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (!rst_b) begin
            cand_valid_q <= 1'b0;
            cand_idx_q   <= 5'h00;
            cand_lvl_q   <= 3'h0;
            nmi_pend_q   <= 1'b0;
            aerr_pend_q  <= 1'b0;
            trace_pend_q <= 1'b0;
            hold_q       <= 1'b0;
        end else begin
            cand_valid_q <= best_valid;
            cand_idx_q   <= best_idx;
            cand_lvl_q   <= best_lvl;
            aerr_pend_q  <= addr_err_req | (aerr_pend_q & ~take_byp);
            nmi_pend_q   <= nmi_req | (nmi_pend_q & ~(take_byp & ~aerr_pend_q));
            trace_pend_q <= trace_req | (trace_pend_q & ~(take_byp & ~aerr_pend_q & ~nmi_pend_q));
            // Held through a transfer and one instruction after it
            if (xfer_busy)
                hold_q <= 1'b1;
            else if (instr_done)
                hold_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Service sequence
    // ------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (!rst_b) begin
            state_q      <= ST_IDLE;
            svc_to_xfer  <= 1'b0;
            svc_level    <= 3'h0;
            svc_vec_addr <= 9'h000;
            svc_idx_q    <= 5'h00;
            mode_q       <= 1'b0;
            cnt_q        <= 8'h00;
            src_clr      <= `PIC_SRC_RST;
            trace_clr    <= 1'b0;
            mask_load    <= 1'b0;
            new_mask     <= 3'h0;
            exc_done     <= 1'b0;
        end else begin
            src_clr   <= `PIC_SRC_RST;
            trace_clr <= 1'b0;
            mask_load <= 1'b0;
            exc_done  <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (take_byp) begin
                        state_q     <= ST_OFFER;
                        svc_to_xfer <= 1'b0;
                        mode_q      <= max_mode;
                        // Address error and trace leave the mask unchanged
                        svc_level   <= nmi_pend_q & ~aerr_pend_q ? `PIC_NMI_LEVEL : cpu_mask_level;
                        svc_vec_addr <= vec_addr(aerr_pend_q ? ADDR_ERR_VEC
                                               : nmi_pend_q ? `PIC_NMI_VEC : TRACE_VEC, max_mode);
                    end else if (take_src) begin
                        state_q      <= ST_OFFER;
                        svc_to_xfer  <= to_xfer;
                        mode_q       <= max_mode;
                        svc_idx_q    <= cand_idx_q;
                        svc_level    <= cand_lvl_q;
                        svc_vec_addr <= vec_addr(src_vec(cand_idx_q), max_mode);
                    end
                end
                ST_OFFER: begin
                    if (svc_ack) begin
                        if (svc_to_xfer) begin
                            state_q <= ST_IDLE;
                            // Serial requests clear by data register access instead
                            src_clr <= (`PIC_SRC_RST | 21'h000001) << svc_idx_q
                                     & ~`PIC_SERIAL_MASK;
                        end else begin
                            state_q <= ST_WAIT;
                        end
                    end
                end
                ST_WAIT: begin
                    if (instr_done) begin
                        state_q   <= ST_SAVE;
                        cnt_q     <= save_states(mode_q, ext_stack, wait_states) - 8'h01;
                        trace_clr <= 1'b1;
                        mask_load <= 1'b1;
                        new_mask  <= svc_level;
                    end
                end
                ST_SAVE: begin
                    if (save_end) begin
                        state_q  <= ST_IDLE;
                        exc_done <= 1'b1;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

endmodule // pic_ctrl

// file: dv/pic_far_model.sv
// Far-side model: CPU core and transfer controller
module pic_far_model (
    input  logic       ref_clk,
    input  logic       rst_b,
    input  logic       svc_valid,
    input  logic       svc_to_xfer,
    input  logic [1:0] slow,
    output logic       svc_ack,
    output logic       instr_done,
    output logic       xfer_busy
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] wait_q;
    logic [1:0] ins_q;
    logic [1:0] busy_q;
    assign xfer_busy = busy_q != 2'h0;
    always @(posedge ref_clk) begin
        if (!rst_b) begin
            wait_q <= 2'h0;
            ins_q <= 2'h0;
            busy_q <= 2'h0;
            svc_ack <= 1'b0;
            instr_done <= 1'b0;
        end else begin
            // One ack per offer, after a chosen stall
            svc_ack <= svc_valid && !svc_ack && wait_q >= slow;
            wait_q <= (svc_valid && !svc_ack && wait_q < slow) ? wait_q + 2'h1 : 2'h0;
            ins_q <= ins_q + 2'h1;
            instr_done <= ins_q == 2'h3;
            busy_q <= (svc_ack && svc_valid && svc_to_xfer) ? 2'h3 : busy_q - {1'b0, xfer_busy};
        end
    end
endmodule // pic_far_model

// file: dv/pic_ctrl_sva.sv
// Assertion checker for the priority interrupt controller
`include "pic_defs.vh"
module pic_ctrl_sva (
    input logic        ref_clk,
    input logic        rst_b,
    input logic        svc_valid,
    input logic        svc_to_xfer,
    input logic [2:0]  svc_level,
    input logic [8:0]  svc_vec_addr,
    input logic        svc_ack,
    input logic [2:0]  cpu_mask_level,
    input logic [20:0] src_clr,
    input logic        ctx_save,
    input logic        save_code_page,
    input logic [1:0]  vec_words,
    input logic        max_mode,
    input logic        ext_stack,
    input logic [3:0]  wait_states,
    input logic        trace_clr,
    input logic        mask_load,
    input logic [2:0]  new_mask,
    input logic        exc_done
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] cnt_q;
    logic [2:0] lvl_q;
    logic [7:0] len;
    // Mode inputs must stay steady across a save for this to hold
    assign len = ext_stack ? (max_mode ? `PIC_SAVE_MAX_EXT + `PIC_SAVE_MAX_PERWAIT * {4'h0, wait_states}
                                       : `PIC_SAVE_MIN_EXT + `PIC_SAVE_MIN_PERWAIT * {4'h0, wait_states})
                           : (max_mode ? `PIC_SAVE_MAX_ONCHIP : `PIC_SAVE_MIN_ONCHIP);
    always @(posedge ref_clk) begin
        if (!rst_b) begin
            cnt_q <= 8'h00;
            lvl_q <= 3'h0;
        end else begin
            cnt_q <= ctx_save ? cnt_q + 8'h01 : 8'h00;
            lvl_q <= (svc_valid && svc_ack && !svc_to_xfer) ? svc_level : lvl_q;
        end
    end
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);
    property p_hold; svc_valid && !svc_ack |=> svc_valid && $stable({svc_to_xfer, svc_level, svc_vec_addr}); endproperty
    a_hold: assert property (p_hold) else $error("offer changed before ack");
    property p_drop; svc_valid && svc_ack |=> !svc_valid; endproperty
    a_drop: assert property (p_drop) else $error("offer stayed after ack");
    property p_gate; $rose(svc_valid) |-> (svc_to_xfer ? svc_level > $past(cpu_mask_level)
                                                       : svc_level >= $past(cpu_mask_level)); endproperty
    a_gate: assert property (p_gate) else $error("offer level not above mask");
    property p_clr; |src_clr |-> $past(svc_valid && svc_to_xfer && svc_ack); endproperty
    a_clr: assert property (p_clr) else $error("clear without transfer start");
    property p_serial; $onehot0(src_clr) && (src_clr & `PIC_SERIAL_MASK) == 21'h0; endproperty
    a_serial: assert property (p_serial) else $error("bad request clear");
    property p_start; $rose(ctx_save) |-> mask_load && trace_clr && new_mask == lvl_q; endproperty
    a_start: assert property (p_start) else $error("mask or trace not updated");
    property p_len; $fell(ctx_save) |-> cnt_q == len; endproperty
    a_len: assert property (p_len) else $error("save length wrong");
    property p_done; $fell(ctx_save) |-> ##[0:1] exc_done; endproperty
    a_done: assert property (p_done) else $error("no end of save pulse");
    property p_words; ctx_save |-> vec_words == (max_mode ? 2'h2 : 2'h1)
                                   && save_code_page == max_mode; endproperty
    a_words: assert property (p_words) else $error("vector word count wrong");
    c_xfer: cover property (svc_valid && svc_ack && svc_to_xfer);
    c_max_ext: cover property ($rose(ctx_save) && max_mode && ext_stack);
    c_top: cover property (svc_valid && svc_level == 3'h7 && !svc_to_xfer);
endmodule // pic_ctrl_sva
bind pic_ctrl pic_ctrl_sva u_sva (.*);

// file: dv/pic_ctrl_tb.sv
// Self-checking testbench for the priority interrupt controller
`include "pic_defs.vh"
module pic_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic nmi_req = 1'b0, addr_err_req = 1'b0, trace_req = 1'b0, max_mode = 1'b0, ext_stack = 1'b0;
    logic [17:0] paddr = 18'h0;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [20:0] src_req = 21'h0, src_clr, xen;
    logic [2:0]  cpu_mask_level = 3'h0, svc_level, new_mask;
    logic [3:0]  wait_states = 4'h0;
    logic [1:0]  slow = 2'h0, vec_words;
    logic pready, pslverr, svc_valid, svc_to_xfer, svc_ack, ctx_save, save_code_page;
    logic trace_clr, mask_load, exc_done, irq, instr_done, xfer_busy;
    logic [8:0]  svc_vec_addr;
    logic [32:0] rd_q[$], e;
    logic [17:0] of_q[$], o;
    logic [7:0]  prio[4];
    logic [7:0]  base[8] = '{8'h40, 8'h42, 8'h48, 8'h50, 8'h58, 8'h60, 8'h68, 8'h70};
    int first[8] = '{0, 1, 2, 6, 10, 14, 17, 20};
    int failures = 0, cmp_count = 0, seed = 89870, cyc = 0;
    pic_ctrl u_dut (.*);
    pic_far_model u_far (.*);
    always #50 ref_clk = ~ref_clk;
    task automatic cmp_val(input logic [32:0] got, input logic [32:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t value %h expected %h", $time, got, exp);
        end
    endtask
    task automatic irq_is(input logic exp);
        @(negedge ref_clk);
        cmp_val({32'h0, irq}, {32'h0, exp});
    endtask
    task automatic apb(input logic [15:0] idx, input logic wr, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] idx, input logic [32:0] exp);
        rd_q.push_back(exp);
        apb(idx, 1'b0, 32'h0);
    endtask
    task automatic setp(input int r, input logic [7:0] v);
        prio[r] = v & `PIC_PRIO_WMASK;
        apb(16'hfff0 + 16'(r), 1'b1, {24'h0, v});
    endtask
    function automatic logic [17:0] exp_off(input int i);
        int m;
        logic [7:0] v;
        logic [2:0] lv;
        m = i < 2 ? i : i < 6 ? 2 : i < 10 ? 3 : i < 14 ? 4 : i < 17 ? 5 : i < 20 ? 6 : 7;
        v = base[m] + 8'(2 * (i - first[m]));
        lv = m[0] ? prio[m / 2][2:0] : prio[m / 2][6:4];
        return {5'(i), xen[i] & |(`PIC_XFER_CAPABLE & (21'h1 << i)), lv, max_mode ? {v, 1'b0} : {1'b0, v}};
    endfunction
    task automatic settle;
        repeat (8) @(posedge ref_clk);
        while (of_q.size() != 0 || svc_valid || ctx_save) @(posedge ref_clk);
        repeat (8) @(posedge ref_clk);
        while (ctx_save) @(posedge ref_clk);
        repeat (3) @(posedge ref_clk);
    endtask
    // Expected offers are queued in service order, which here is index order
    task automatic serve(input logic [20:0] bits);
        for (int i = 0; i < 21; i++) if (bits[i]) of_q.push_back(exp_off(i));
        slow <= 2'($random(seed));
        for (int i = 0; i < 21; i++) if (bits[i]) src_req[i] <= 1'b1;
        settle();
    endtask
    task automatic bypass(input int k, input logic mx);
        logic [7:0] v;
        v = k == 0 ? 8'h08 : k == 1 ? `PIC_NMI_VEC : 8'h0c;
        max_mode <= mx;
        of_q.push_back({5'd31, 1'b0, 3'h7, mx ? {v, 1'b0} : {1'b0, v}});
        {trace_req, nmi_req, addr_err_req} <= 3'(1 << k);
        @(posedge ref_clk);
        {trace_req, nmi_req, addr_err_req} <= 3'h0;
        settle();
    endtask
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // ----------------------------------------
    // Result watcher
    // ----------------------------------------
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            failures++;
            finish_test();
        end
        if (psel && penable && pready && !pwrite) begin
            e = rd_q.size() ? rd_q.pop_front() : 'x;
            cmp_val({pslverr, prdata}, e);
        end
        if (svc_valid && svc_ack) begin
            o = of_q.size() ? of_q.pop_front() : 'x;
            cmp_val({20'h0, svc_to_xfer, svc_level, svc_vec_addr}, {20'h0, o[12:0]});
            if (o[17:13] < 5'd21) src_req[o[17:13]] <= 1'b0;
        end
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        xen = 21'h0;
        repeat (2) @(posedge ref_clk);
        rst_b <= 1'b1;
        for (int r = 0; r < 4; r++) rd(16'hfff0 + 16'(r), 33'h0);
        rd(16'hfff5, {1'b1, 32'h0});
        for (int r = 0; r < 4; r++) begin
            setp(r, 8'($random(seed)));
            rd(16'hfff0 + 16'(r), {25'h0, prio[r]});
        end
        setp(0, 8'hff);
        rd(16'hfff0, 33'h77);
        setp(0, 8'h75);
        setp(1, 8'h33);
        setp(3, 8'h71);
        serve(21'h3);
        serve(21'h64);
        cpu_mask_level <= 3'h3;
        src_req[2] <= 1'b1;
        repeat (20) @(posedge ref_clk);
        of_q.push_back(exp_off(2));
        cpu_mask_level <= 3'h2;
        settle();
        cpu_mask_level <= 3'h7;
        for (int k = 0; k < 6; k++) bypass(k / 2, k[0]);
        cpu_mask_level <= 3'h0;
        max_mode <= 1'b0;
        xen = 21'h40001;
        apb(16'hfff4, 1'b1, {11'h0, xen});
        serve(21'h40001);
        for (int r = 0; r < 4; r++) setp(r, 8'($random(seed)) | 8'h11);
        xen = 21'($random(seed));
        apb(16'hfff4, 1'b1, {11'h0, xen});
        for (int i = 0; i < 21; i++) begin
            max_mode <= 1'($random(seed));
            ext_stack <= 1'($random(seed));
            wait_states <= 4'($random(seed));
            @(posedge ref_clk);
            serve(21'h1 << i);
        end
        xen = 21'h0;
        apb(16'hfff4, 1'b1, 32'h0);
        apb(16'hfffa, 1'b1, 32'hf);
        apb(16'hfff9, 1'b1, 32'h1);
        irq_is(1'b0);
        serve(21'h1);
        rd(16'hfff8, 33'h9);
        rd(16'hfffb, {22'h0, prio[0][6:4], 8'h0});
        irq_is(1'b1);
        apb(16'hfff9, 1'b1, 32'h0);
        irq_is(1'b0);
        apb(16'hfff9, 1'b1, 32'h1);
        irq_is(1'b1);
        apb(16'hfffa, 1'b1, 32'h1);
        irq_is(1'b0);
        finish_test();
    end
endmodule // pic_ctrl_tb
